// ==== hw/upp_pkg.sv ====
// Package for the USB port power and over-current monitor.
// Assumes a single 40 MHz clock domain and five ports sharing one layout.
`default_nettype none
package upp_pkg;
  localparam int unsigned UPP_NUM_PORTS = 5;
  localparam int unsigned UPP_CLK_MHZ   = 40;
  // Least time the line must stay released before a falling edge may count as a fault.
  localparam int unsigned UPP_SETTLE_NS = 1000;
  localparam int unsigned UPP_SETTLE_CYC =
    ((UPP_SETTLE_NS * UPP_CLK_MHZ) + 999) / 1000;
  localparam int unsigned UPP_CNT_W = 8;
  // Reset values of per-port state.
  localparam logic        UPP_DRIVE_RST   = 1'b1;
  localparam logic        UPP_PULLUP_RST  = 1'b0;
  localparam logic        UPP_FAULT_RST   = 1'b0;
  // Port state encodings, one-hot.
  typedef enum logic [3:0] {
    UPP_OFF     = 4'b0001,
    UPP_SETTLE  = 4'b0010,
    UPP_ON      = 4'b0100,
    UPP_TRIPPED = 4'b1000
  } upp_state_e;
endpackage : upp_pkg
`default_nettype wire

// ==== hw/upp_sync2.sv ====
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the inputs are static levels, not multi-bit coherent words.
`default_nettype none
module upp_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  // Only the second stage reads the first, so metastability never fans out.
  always_comb begin
    meta_nxt = resetn ? async_in : rst_val;
    sync_nxt = resetn ? meta_r : rst_val;
  end

  // Registers only; the reset value is applied synchronously above.
  always_ff @(posedge clk) begin
    meta_r   <= meta_nxt;
    sync_out <= sync_nxt;
  end
endmodule // upp_sync2
`default_nettype wire

// ==== hw/upp_port_power.sv ====
// Per-port USB power enable and over-current monitor for five ports.
// Assumes an external 3.3V pull-up on each shared line, a carrier power
// switch with its enable and fault output tied onto that line, and one clock.
//
// Overview of operation
// - To cut a port's power the block pulls its shared line low through an open-drain driver.
// - To grant power the block releases the line so the pull-up raises it and enables the switch.
// - A falling edge on the line while the port is fully on, past the settle wait, is reported as an over-current event.
// - A low line caused by the block's own drive is never reported as over-current.
// - Each line has a pull-up and every driver on it, this block's included, is open-drain.
// - Power is granted only once a device connection has been seen on that port's data lines.
// - The pull-up supply of an unused port may be switched off to save power.
// - The role-identification input is active high.
// - In device role the host-power-detect input shows that the upstream host supplies bus power.
//
// Timing notes
// A fault shows three clock edges after the pin drops: two synchroniser stages
// and one event register, so the event pulse trails the pin slightly.
// The settle wait after release covers the slow rise of the pull-up; a fault in
// that wait goes unreported, which is the price paid for a clean start-up.
// After a trip the block holds the line low itself, so the switch stays off
// until software drops the enable request and then renews it.
// The pull-up rail follows the in-use input, so an unused port reads low; that
// level is taken for a fault only if the rail drops while the port is fully enabled, since only then is the line watched.
`default_nettype none
module upp_port_power (
  input  wire logic                                clk,
  input  wire logic                                resetn,
  input  wire logic [upp_pkg::UPP_NUM_PORTS-1:0]   port_enable_req,
  input  wire logic [upp_pkg::UPP_NUM_PORTS-1:0]   port_in_use,
  input  wire logic [upp_pkg::UPP_NUM_PORTS-1:0]   device_connected,
  input  wire logic [upp_pkg::UPP_NUM_PORTS-1:0]   fault_clear,
  input  wire logic [upp_pkg::UPP_NUM_PORTS-1:0]   port_power_fault_line_n_in,
  output logic      [upp_pkg::UPP_NUM_PORTS-1:0]   port_power_fault_line_n_out,
  output logic      [upp_pkg::UPP_NUM_PORTS-1:0]   port_power_fault_line_n_oe,
  output logic      [upp_pkg::UPP_NUM_PORTS-1:0]   pullup_supply_en,
  output logic      [upp_pkg::UPP_NUM_PORTS-1:0]   port_powered,
  output logic      [upp_pkg::UPP_NUM_PORTS-1:0]   overcurrent_fault,
  output logic      [upp_pkg::UPP_NUM_PORTS-1:0]   overcurrent_event,
  input  wire logic                                host_power_detect,
  input  wire logic                                role_id_input,
  output logic                                     host_role,
  output logic                                     host_power_present
);
  import upp_pkg::*;

  // Local short names for the port count and the settle limit in clock cycles.
  localparam int unsigned N = UPP_NUM_PORTS;
  localparam logic [UPP_CNT_W-1:0] SETTLE_CNT = UPP_CNT_W'(UPP_SETTLE_CYC);

  // Power counts as granted in both the settle and the on state; one decode
  // names those states so the powered flag cannot drift from the state machine.
  function automatic logic port_live(input upp_state_e s);
    return (s == UPP_SETTLE) || (s == UPP_ON);
  endfunction

  // A high-to-low step between two synchronised samples of one line.
  function automatic logic line_fell(input logic prev_lvl, input logic cur_lvl);
    return prev_lvl & ~cur_lvl;
  endfunction

  // Synchronised pin levels: five lines plus the two role inputs.
  // They come from pins off the clock's domain, so two flops stand before any logic.
  logic [N-1:0] line_s;
  logic [N+1:0] pins_s;

  upp_sync2 #(.W(N + 2)) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({role_id_input, host_power_detect, port_power_fault_line_n_in}),
    .rst_val  ({2'b00, {N{1'b1}}}),
    .sync_out (pins_s)
  );
  assign line_s = pins_s[N-1:0];

  // Per-port state. Each port is independent: bit i of every vector and entry
  // i of every array belong to port i, and no port's logic reads another's.
  // The fault flag and the event pulse are kept apart so that software may poll
  // the sticky flag while an interrupt source can use the one-cycle pulse.
  upp_state_e            state_r    [N];
  upp_state_e            state_nxt  [N];
  logic [UPP_CNT_W-1:0]  cnt_r      [N];
  logic [UPP_CNT_W-1:0]  cnt_nxt    [N];
  logic [N-1:0]          line_prev_r;
  logic [N-1:0]          line_prev_nxt;
  logic [N-1:0]          drive_r;
  logic [N-1:0]          drive_nxt;
  logic [N-1:0]          pullup_r;
  logic [N-1:0]          pullup_nxt;
  logic [N-1:0]          fault_r;
  logic [N-1:0]          fault_nxt;
  logic [N-1:0]          event_r;
  logic [N-1:0]          event_nxt;
  logic [N-1:0]          powered_r;
  logic [N-1:0]          powered_nxt;
  logic                  role_r;
  logic                  role_nxt;
  logic                  vbus_r;
  logic                  vbus_nxt;

  // Edge-detector history resets to the released level, so the first pin sample
  // after reset looks like a falling edge on a low line; the port is at most in SETTLE then, never ON.
  always_comb begin
    line_prev_nxt = resetn ? line_s : {N{1'b1}};
  end

  // History register for the edge detector.
  always_ff @(posedge clk) begin
    line_prev_r <= line_prev_nxt;
  end

  // Role inputs form a group of their own; bus power is masked in host role so
  // a port that supplies the bus never mistakes its own supply for a host.
  always_comb begin
    role_nxt = resetn ? pins_s[N+1] : 1'b0;
    vbus_nxt = resetn ? (pins_s[N] & ~pins_s[N+1]) : 1'b0;
  end

  // Role registers.
  always_ff @(posedge clk) begin
    role_r <= role_nxt;
    vbus_r <= vbus_nxt;
  end

  // A falling edge only counts once the port is fully on; the settle wait keeps
  // the pull-up's slow rise after release from being mistaken for a fault.
  always_comb begin
    logic fall;
    fall          = 1'b0;
    for (int i = 0; i < N; i++) begin
      fall           = line_fell(line_prev_r[i], line_s[i]);
      state_nxt[i]   = state_r[i];
      cnt_nxt[i]     = cnt_r[i];
      drive_nxt[i]   = drive_r[i];
      event_nxt[i]   = 1'b0;
      pullup_nxt[i]  = port_in_use[i];
      unique case (state_r[i])
        UPP_OFF: begin
          drive_nxt[i] = 1'b1;
          if (port_enable_req[i] && device_connected[i]) begin
            state_nxt[i] = UPP_SETTLE;
            drive_nxt[i] = 1'b0;
            cnt_nxt[i]   = '0;
          end
        end
        UPP_SETTLE: begin
          if (!port_enable_req[i]) begin
            state_nxt[i] = UPP_OFF;
            drive_nxt[i] = 1'b1;
          end else if (cnt_r[i] == SETTLE_CNT) begin
            state_nxt[i] = UPP_ON;
          end else begin
            cnt_nxt[i] = cnt_r[i] + 1'b1;
          end
        end
        UPP_ON: begin
          if (!port_enable_req[i]) begin
            state_nxt[i] = UPP_OFF;
            drive_nxt[i] = 1'b1;
          end else if (fall) begin
            event_nxt[i] = 1'b1;
            state_nxt[i] = UPP_TRIPPED;
          end
        end
        UPP_TRIPPED: begin
          // The switch has cut itself off; hold the line low until software drops the request.
          drive_nxt[i] = 1'b1;
          if (!port_enable_req[i]) begin
            state_nxt[i] = UPP_OFF;
          end
        end
        default: begin
          state_nxt[i] = UPP_OFF;
          drive_nxt[i] = 1'b1;
        end
      endcase
      // Events in OFF or TRIPPED are ignored since our own drive holds the line low.
      // Set beats clear so a fault in the clearing cycle is kept.
      fault_nxt[i]   = event_nxt[i] | (fault_r[i] & ~fault_clear[i]);
      powered_nxt[i] = port_live(state_nxt[i]);
      // Reset is applied last, so it overrides every arm above.
      if (!resetn) begin
        state_nxt[i]   = UPP_OFF;
        cnt_nxt[i]     = '0;
        drive_nxt[i]   = UPP_DRIVE_RST;
        pullup_nxt[i]  = UPP_PULLUP_RST;
        event_nxt[i]   = 1'b0;
        fault_nxt[i]   = UPP_FAULT_RST;
        powered_nxt[i] = 1'b0;
      end
    end
  end

  // State registers; reset is folded into the next-value logic, so no flop
  // needs a reset pin and every register sees the same plain clock edge.
  always_ff @(posedge clk) begin
    state_r     <= state_nxt;
    cnt_r       <= cnt_nxt;
    drive_r     <= drive_nxt;
    pullup_r    <= pullup_nxt;
    fault_r     <= fault_nxt;
    event_r     <= event_nxt;
    powered_r   <= powered_nxt;
  end

  // Open-drain pins: the output data is always low, only the enable moves.
  // Keeping the data low and moving only the enable means this block never drives high.
  assign port_power_fault_line_n_out = '0;
  assign port_power_fault_line_n_oe  = drive_r;
  assign pullup_supply_en            = pullup_r;
  assign port_powered                = powered_r;
  assign overcurrent_fault           = fault_r;
  assign overcurrent_event           = event_r;
  assign host_role                   = role_r;
  assign host_power_present          = vbus_r;
endmodule // upp_port_power
`default_nettype wire

// ==== verif/upp_carrier.sv ====
// Carrier power switch model for the five shared port lines.
// Assumes the bench raises trip to force an over-current.
`default_nettype none
module upp_carrier (
  input  wire logic [4:0] oe,
  input  wire logic [4:0] pu_en,
  input  wire logic [4:0] trip,
  output logic      [4:0] line
);
  // The switch enable is the line itself, so its fault pull also shuts it off.
  assign line = pu_en & ~oe & ~trip;
endmodule // upp_carrier
`default_nettype wire

// ==== verif/upp_port_power_assertions.sv ====
// Checker for the port power block, watching its top-level ports.
// Assumes one clock and the synchronous active-low reset.
`default_nettype none
module upp_port_power_assertions (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [4:0] port_in_use,
  input wire logic [4:0] device_connected,
  input wire logic [4:0] fault_clear,
  input wire logic [4:0] port_power_fault_line_n_in,
  input wire logic [4:0] port_power_fault_line_n_out,
  input wire logic [4:0] port_power_fault_line_n_oe,
  input wire logic [4:0] pullup_supply_en,
  input wire logic [4:0] port_powered,
  input wire logic [4:0] overcurrent_fault,
  input wire logic [4:0] overcurrent_event,
  input wire logic       host_role,
  input wire logic       host_power_present
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Each check but od_low_a and event_pulse_a ties an output to its cause, so a stuck register shows up.
  od_low_a:
    assert property (port_power_fault_line_n_out == 5'h0) else $error("not open drain");
  grant_conn_a:
    assert property ((port_powered & ~$past(port_powered) & ~$past(device_connected)) == 5'h0)
      else $error("power without device");
  power_release_a:
    assert property ((port_powered & port_power_fault_line_n_oe) == 5'h0)
      else $error("powered port held low");
  event_sets_a:
    assert property ((overcurrent_event & ~overcurrent_fault) == 5'h0) else $error("no latch");
  self_low_a:
    assert property ((overcurrent_event & $past(port_power_fault_line_n_oe)) == 5'h0)
      else $error("own drive reported");
  event_pulse_a:
    assert property ((overcurrent_event & $past(overcurrent_event)) == 5'h0)
      else $error("event too long");
  event_cause_a:
    assert property ((overcurrent_event & $past(port_power_fault_line_n_in, 3)) == 5'h0)
      else $error("event without fall");
  fault_sticky_a:
    assert property ((~overcurrent_fault & $past(overcurrent_fault & ~fault_clear)) == 5'h0)
      else $error("fault lost");
  pullup_use_a:
    assert property ($past(resetn) |-> pullup_supply_en == $past(port_in_use))
      else $error("pull-up rail wrong");
  role_gate_a:
    assert property (!(host_role && host_power_present)) else $error("bus power in host role");
endmodule // upp_port_power_assertions
bind upp_port_power upp_port_power_assertions chk (.clk, .resetn, .port_in_use,
  .device_connected, .fault_clear, .port_power_fault_line_n_in, .port_power_fault_line_n_out,
  .port_power_fault_line_n_oe, .pullup_supply_en, .port_powered, .overcurrent_fault,
  .overcurrent_event, .host_role, .host_power_present);
`default_nettype wire

// ==== verif/upp_port_power_test.sv ====
// Bench for the port power block with a carrier switch model.
// Assumes the checker file binds itself to the block.
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module upp_port_power_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, host_power_detect = 0, role_id_input = 0;
  logic host_role, host_power_present;
  logic [4:0] port_enable_req = 0, port_in_use = 0, device_connected = 0, fault_clear = 0;
  logic [4:0] trip = 0, port_power_fault_line_n_out, port_power_fault_line_n_oe;
  logic [4:0] pullup_supply_en, port_powered, overcurrent_fault, overcurrent_event;
  wire logic [4:0] port_power_fault_line_n_in;
  int error_cnt = 0, cmp_count = 0;
  // Clock at 40 MHz.
  always #12.5 clk = ~clk;
  upp_port_power dut (.clk, .resetn, .port_enable_req, .port_in_use, .device_connected,
    .fault_clear, .port_power_fault_line_n_in, .port_power_fault_line_n_out,
    .port_power_fault_line_n_oe, .pullup_supply_en, .port_powered, .overcurrent_fault,
    .overcurrent_event, .host_power_detect, .role_id_input, .host_role, .host_power_present);
  upp_carrier sw (.oe(port_power_fault_line_n_oe), .pu_en(pullup_supply_en), .trip,
    .line(port_power_fault_line_n_in));
  // Sampling 1 ns after the edge lets its updates land first.
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Only ports 1 and 3 see a device, so only they may be powered.
  task automatic grant;
    @(posedge clk);
    port_in_use <= 5'h1f;
    port_enable_req <= 5'h1f;
    device_connected <= 5'h0a;
    cyc(2);
    `CHK("powered", 5'h0a, port_powered)
    `CHK("line", 5'h0a, port_power_fault_line_n_in)
    `CHK("odata", 5'h00, port_power_fault_line_n_out)
    `CHK("pullup", 5'h1f, pullup_supply_en)
  endtask
  // A short fault on port 3 must pulse once, latch and wait for a clear.
  task automatic overcurrent;
    int n;
    n = 0;
    cyc(45);
    @(posedge clk);
    trip <= 5'h08;
    cyc(1);
    while (overcurrent_event !== 5'h08 && n < 10) begin
      cyc(1);
      n++;
    end
    `CHK("event", 5'h08, overcurrent_event)
    `CHK("latency", 2, n)
    cyc(1);
    `CHK("pulse", 5'h00, overcurrent_event)
    `CHK("oe", 5'h1d, port_power_fault_line_n_oe)
    // The switch lets go on a clock edge, once the block already holds the line low.
    @(posedge clk);
    trip <= 5'h00;
    cyc(1);
    `CHK("held", 5'h02, port_power_fault_line_n_in)
    `CHK("plain", 5'h02, port_powered)
    cyc(3);
    `CHK("sticky", 5'h08, overcurrent_fault)
    @(posedge clk);
    fault_clear <= 5'h08;
    @(posedge clk);
    fault_clear <= 5'h00;
    cyc(0);
    `CHK("clear", 5'h00, overcurrent_fault)
  endtask
  // Dropping power pulls the lines low, which must not count as a fault.
  task automatic drop;
    @(posedge clk);
    port_enable_req <= 5'h00;
    port_in_use <= 5'h00;
    cyc(6);
    `CHK("off", 5'h1f, port_power_fault_line_n_oe)
    `CHK("nofault", 5'h00, overcurrent_fault)
    `CHK("rail", 5'h00, pullup_supply_en)
  endtask
  // Bus power shows only in device role; a high role input means host.
  task automatic role;
    @(posedge clk);
    host_power_detect <= 1'b1;
    cyc(4);
    `CHK("vbus", 1'b1, host_power_present)
    @(posedge clk);
    role_id_input <= 1'b1;
    cyc(4);
    `CHK("role", 2'b10, {host_role, host_power_present})
  endtask
  // Main sequence, after reset held for 10 cycles.
  initial begin
    cyc(10);
    `CHK("reset", 5'h1f, port_power_fault_line_n_oe)
    @(posedge clk);
    resetn <= 1'b1;
    grant;
    overcurrent;
    drop;
    role;
    conclude;
  end
  // Watchdog, far beyond the roughly 90 cycles the tests need.
  initial begin
    #20us;
    error_cnt++;
    conclude;
  end
endmodule // upp_port_power_test
`default_nettype wire
